// *** rtl/cbs_pkg.sv ***
// What this block does
// (RULE1) Keep three banks: 32-48k, 16-24k, other rates.
// (RULE2) Bits 2:0 of register coefficient_bank_control control switching.
// (RULE3) Reset 000: coefficient writes go to processor; of a biquad the code sends only the fifth word (word 4).
// (RULE4) Codes 001-011 route coefficient writes into store.
// (RULE5) Host writes 100 after loading all banks.
// (RULE6) Automatic state swaps bank on rate change.
// (RULE7) Host first writes 0x00 to trim register.
// (RULE8) Host loads banks 1,2,3 then writes 0x04.
// (RULE9) Host clears bit 6 of register channel_shutdown_control.
// (RULE10) Volume code 0x30 means 0 dB.
// (RULE11) Mixer gains are 26-bit signed 3.23 values.
// (RULE12) Host sends each gain as four bytes.
// (RULE13) In 9.17 format 0x00020000 is unity.
// (RULE14) Biquad holds b0, b1, b2, a1, a2.
// (RULE15) One compressor for left/right, one for sub.
// (RULE16) Compressors have energy, attack, decay constants.
// (RULE17) Biquad write is five words; partial is discarded.
// (RULE18) Host uses 4-byte multiples above 0x1f.
// (RULE19) 3.23 sits in low 26 bits; upper ignored.
package cbs_pkg;
    localparam logic [7:0] ADDR_SHUTDOWN = 8'h05;
    localparam logic [7:0] ADDR_VOLUME = 8'h07;
    localparam logic [7:0] ADDR_TRIM = 8'h1b;
    localparam logic [7:0] ADDR_BANK_CTRL = 8'h50;
    localparam logic [7:0] ADDR_WIDE_FIRST = 8'h20;
    localparam logic [7:0] COEF_LO_FIRST = 8'h29;
    localparam logic [7:0] COEF_LO_LAST = 8'h3f;
    localparam logic [7:0] COEF_HI_FIRST = 8'h58;
    localparam logic [7:0] COEF_HI_LAST = 8'h5f;
    localparam logic [7:0] BIQUAD_FIRST = 8'h29;
    localparam logic [7:0] BIQUAD_LAST = 8'h36;
    localparam int COEF_SLOTS = 31;
    localparam int WORDS_PER_SLOT = 5;
    localparam int BIQUAD_WORDS = 5;
    localparam logic [7:0] SHUTDOWN_RESET = 8'h40;
    localparam int SHUTDOWN_BIT = 6;
    localparam logic [7:0] VOLUME_RESET = 8'hff;
    localparam logic [7:0] VOLUME_UNITY = 8'h30;
    localparam logic [7:0] TRIM_RESET = 8'h01;
    localparam logic [2:0] BANK_FIELD_RESET = 3'h0;
    localparam int GAIN_WIDTH = 26;
    localparam logic [31:0] GAIN_UNITY_323 = 32'h00800000;
    localparam logic [31:0] GAIN_UNITY_917 = 32'h00020000; // see (RULE13)
    localparam logic [1:0] RATE_32_48 = 2'h0;
    localparam logic [1:0] RATE_16_24 = 2'h1;
    localparam logic [1:0] RATE_OTHER = 2'h2;

    typedef enum logic [2:0]
    {
        MODE_DIRECT,
        MODE_FILL_FIRST,
        MODE_FILL_SECOND,
        MODE_FILL_THIRD,
        MODE_AUTO
    } cbs_mode_t;

    typedef struct packed
    {
        logic start;
        logic stop;
        logic byte_valid;
        logic [7:0] byte_data;
    } cbs_serial_t;

    typedef struct packed
    {
        logic valid;
        logic [7:0] slot;
        logic [2:0] word;
        logic [31:0] data;
    } cbs_coef_t;
endpackage

// *** rtl/cbs_word_gather.sv ***
`timescale 1ns/100ps
module cbs_word_gather
    import cbs_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_enable,
    input wire logic i_clear,
    input wire logic i_byte_valid,
    input wire logic [7:0] i_byte,
    output logic o_word_valid,
    output logic [31:0] o_word
);
    logic [1:0] count;
    logic [1:0] next_count;
    logic [31:0] shift;
    logic [31:0] next_shift;
    logic next_valid;

    always_comb
    begin
        next_count = count;
        next_shift = shift;
        next_valid = 1'b0;
        if (i_clear)
        begin
            next_count = 2'h0;
        end
        else if (i_byte_valid)
        begin
            next_shift = {shift[23:0], i_byte};
            next_count = count + 2'h1;
            next_valid = (count == 2'h3); // see (RULE12)
        end
    end

    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            count <= 2'h0;
            shift <= 32'h0;
            o_word_valid <= 1'b0;
        end
        else if (i_enable)
        begin
            count <= next_count;
            shift <= next_shift;
            o_word_valid <= next_valid;
        end
    end

    assign o_word = shift;
endmodule

// *** rtl/cbs_bank_switch.sv ***
`timescale 1ns/100ps
module cbs_bank_switch
    import cbs_pkg::*;
#(
    parameter int SLOTS = COEF_SLOTS,
    parameter int WORDS = WORDS_PER_SLOT
)
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_enable,
    input wire cbs_serial_t i_serial,
    input wire logic [1:0] i_rate_group,
    input wire logic i_rate_change,
    output cbs_coef_t o_coef,
    output logic [2:0] o_bank_field,
    output logic [1:0] o_active_bank,
    output logic o_shutdown,
    output logic [7:0] o_volume,
    output logic o_volume_unity,
    output logic [7:0] o_trim
);
    localparam int DEPTH = SLOTS * WORDS;
    localparam int AW = $clog2(DEPTH);

    // ----------------------------------------------------------------
    // Stored banks, one per rate group.
    // ----------------------------------------------------------------
    logic [GAIN_WIDTH-1:0] store [3][DEPTH]; // see (RULE1) (RULE15) (RULE16) (RULE19)

    logic have_addr;
    logic [7:0] addr;
    logic [2:0] word;
    logic [7:0] slot_base;
    logic [31:0] pend [BIQUAD_WORDS];
    cbs_mode_t mode;
    logic copying;
    logic [AW-1:0] copy_idx;
    logic [1:0] copy_bank;
    logic next_have_addr;
    logic [7:0] next_addr;
    logic [2:0] next_word;
    cbs_mode_t next_mode;
    logic next_copying;
    logic [AW-1:0] next_copy_idx;
    logic [1:0] next_copy_bank;
    logic word_valid;
    logic [31:0] word_data;
    logic is_coef;
    logic is_biquad;
    logic narrow_byte;
    logic commit;
    logic [AW-1:0] store_idx;
    logic [1:0] fill_bank;
    logic store_write;
    logic [2:0][DEPTH-1:0] written;

    cbs_word_gather u_gather
    (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_enable(i_enable),
        .i_clear(i_serial.start | i_serial.stop),
        .i_byte_valid(i_serial.byte_valid & have_addr & (addr >= ADDR_WIDE_FIRST)),
        .i_byte(i_serial.byte_data),
        .o_word_valid(word_valid),
        .o_word(word_data)
    );

    // ----------------------------------------------------------------
    // Address tracking and bank mode.
    // ----------------------------------------------------------------
    assign is_coef = ((addr >= COEF_LO_FIRST) && (addr <= COEF_LO_LAST))
        || ((addr >= COEF_HI_FIRST) && (addr <= COEF_HI_LAST));
    assign is_biquad = (addr >= BIQUAD_FIRST) && (addr <= BIQUAD_LAST); // see (RULE14)
    assign narrow_byte = i_serial.byte_valid && have_addr && (addr < ADDR_WIDE_FIRST);
    assign commit = word_valid && (!is_biquad || (word == 3'(BIQUAD_WORDS - 1))); // see (RULE17)
    assign slot_base = (addr >= COEF_HI_FIRST) ? (addr - COEF_HI_FIRST + 8'h17)
        : (addr - COEF_LO_FIRST);
    assign store_idx = AW'(slot_base * WORDS + word);
    assign fill_bank = 2'(mode) - 2'h1;
    assign store_write = word_valid && is_coef && commit
        && (mode >= MODE_FILL_FIRST) && (mode <= MODE_FILL_THIRD);

    always_comb
    begin
        next_have_addr = have_addr;
        next_addr = addr;
        next_word = word;
        next_mode = mode;
        next_copying = copying;
        next_copy_idx = copy_idx;
        next_copy_bank = copy_bank;
        if (word_valid)
        begin
            if (addr == ADDR_BANK_CTRL)
            begin
                case (word_data[2:0]) // see (RULE2) (RULE4) (RULE5)
                    3'h1: next_mode = MODE_FILL_FIRST;
                    3'h2: next_mode = MODE_FILL_SECOND;
                    3'h3: next_mode = MODE_FILL_THIRD;
                    3'h4: next_mode = MODE_AUTO;
                    default: next_mode = MODE_DIRECT;
                endcase
            end
            if (commit)
            begin
                next_word = 3'h0;
                next_addr = addr + 8'h1;
            end
            else
            begin
                next_word = word + 3'h1;
            end
        end
        if (i_serial.start || i_serial.stop)
        begin
            next_have_addr = 1'b0;
            next_word = 3'h0; // see (RULE17)
        end
        else if (i_serial.byte_valid && !have_addr)
        begin
            next_have_addr = 1'b1;
            next_addr = i_serial.byte_data;
        end
        else if (narrow_byte)
        begin
            next_addr = addr + 8'h1;
        end
        if (copying)
        begin
            next_copy_idx = copy_idx + AW'(1);
            if (copy_idx == AW'(DEPTH - 1))
            begin
                next_copying = 1'b0;
            end
        end
        if (mode == MODE_AUTO && i_rate_change) // see (RULE6)
        begin
            next_copying = 1'b1;
            next_copy_idx = '0;
            next_copy_bank = (i_rate_group > RATE_OTHER) ? RATE_OTHER : i_rate_group;
        end
    end

    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            have_addr <= 1'b0;
            addr <= 8'h0;
            word <= 3'h0;
            mode <= MODE_DIRECT; // see (RULE3)
            copying <= 1'b0;
            copy_idx <= '0;
            copy_bank <= RATE_32_48;
        end
        else if (i_enable)
        begin
            have_addr <= next_have_addr;
            addr <= next_addr;
            word <= next_word;
            mode <= next_mode;
            copying <= next_copying;
            copy_idx <= next_copy_idx;
            copy_bank <= next_copy_bank;
        end
    end

    // ----------------------------------------------------------------
    // Coefficient routing and held words of a biquad.
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (i_enable)
        begin
            if (word_valid && is_coef)
            begin
                pend[word] <= word_data;
            end
            if (store_write)
            begin
                for (int i = 0; i < BIQUAD_WORDS - 1; i++)
                begin
                    if (3'(i) < word) // see (RULE17)
                    begin
                        store[fill_bank][AW'(slot_base * WORDS + i)] <= pend[i][GAIN_WIDTH-1:0];
                    end
                end
                store[fill_bank][store_idx] <= word_data[GAIN_WIDTH-1:0]; // see (RULE4)
            end
        end
    end

    // ----------------------------------------------------------------
    // Marks of stored words that hold host data.
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            written <= '0;
        end
        else if (i_enable && store_write)
        begin
            for (int i = 0; i < BIQUAD_WORDS; i++)
            begin
                if (3'(i) <= word)
                begin
                    written[fill_bank][AW'(slot_base * WORDS + i)] <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Plain registers and outputs.
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_coef <= '0;
            o_shutdown <= 1'b1;
            o_volume <= VOLUME_RESET;
            o_volume_unity <= 1'b0;
            o_trim <= TRIM_RESET;
            o_bank_field <= BANK_FIELD_RESET;
            o_active_bank <= RATE_32_48;
        end
        else if (i_enable)
        begin
            o_coef.valid <= 1'b0;
            o_bank_field <= 3'(next_mode);
            if (narrow_byte && addr == ADDR_SHUTDOWN)
            begin
                o_shutdown <= i_serial.byte_data[SHUTDOWN_BIT];
            end
            if (narrow_byte && addr == ADDR_VOLUME)
            begin
                o_volume <= i_serial.byte_data;
                o_volume_unity <= (i_serial.byte_data == VOLUME_UNITY); // see (RULE10)
            end
            if (narrow_byte && addr == ADDR_TRIM)
            begin
                o_trim <= i_serial.byte_data;
            end
            if (copying)
            begin
                o_coef.valid <= 1'b1;
                o_coef.slot <= 8'(copy_idx / AW'(WORDS));
                o_coef.word <= 3'(copy_idx % AW'(WORDS));
                o_coef.data <= written[copy_bank][copy_idx]
                    ? 32'(signed'(store[copy_bank][copy_idx])) : 32'h0; // see (RULE11)
                o_active_bank <= copy_bank;
            end
            else if (word_valid && is_coef && commit && mode == MODE_DIRECT) // see (RULE3)
            begin
                o_coef.valid <= 1'b1;
                o_coef.slot <= slot_base;
                o_coef.word <= word;
                o_coef.data <= {{(32 - GAIN_WIDTH){word_data[GAIN_WIDTH-1]}},
                    word_data[GAIN_WIDTH-1:0]}; // see (RULE19)
            end
        end
    end
endmodule

// *** testbench/cbs_bank_switch_checker.sv ***
`timescale 1ns/100ps
module cbs_bank_switch_checker
    import cbs_pkg::*;
#(
    parameter int SLOTS = 31,
    parameter int WORDS = 5
)
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire cbs_serial_t i_serial,
    input wire logic i_rate_change,
    input wire cbs_coef_t o_coef,
    input wire logic [2:0] o_bank_field,
    input wire logic [1:0] o_active_bank,
    input wire logic o_shutdown,
    input wire logic [7:0] o_volume,
    input wire logic o_volume_unity,
    input wire logic [7:0] o_trim
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    sequence s_stream;
        o_coef.valid [*2];
    endsequence
    a_reset_vals: assert property ($fell(i_reset) |-> o_shutdown
        && o_bank_field == 3'h0 && o_volume == VOLUME_RESET && o_trim == TRIM_RESET)
        else $error("reset values wrong");
    a_unity_flag: assert property (o_volume_unity == (o_volume == VOLUME_UNITY))
        else $error("unity flag wrong");
    a_field_legal: assert property (o_bank_field <= 3'h4)
        else $error("bank field out of range");
    a_sign_ext: assert property (o_coef.valid
        |-> o_coef.data[31:26] == {6{o_coef.data[25]}})
        else $error("coefficient not sign extended");
    a_field_cause: assert property ($changed(o_bank_field)
        |-> $past(i_serial.byte_valid)
        || $past(i_serial.byte_valid, 2) || $past(i_serial.byte_valid, 3))
        else $error("bank field changed without a write");
    a_auto_swap: assert property (i_rate_change && o_bank_field == 3'h4
        |-> ##[1:3] s_stream)
        else $error("no bank swap after rate change");
    a_swap_auto_only: assert property ($changed(o_active_bank)
        |-> $past(o_bank_field) == 3'h4)
        else $error("bank swapped outside automatic state");
    a_fill_silent: assert property (o_bank_field inside {3'h1, 3'h2, 3'h3}
        && $stable(o_bank_field) |-> !o_coef.valid)
        else $error("processor written while filling a store");
    a_slot_range: assert property (o_coef.valid
        |-> o_coef.slot < 8'(SLOTS) && o_coef.word < 3'(WORDS))
        else $error("coefficient index out of range");
endmodule

// *** testbench/cbs_host_model.sv ***
`timescale 1ns/100ps
module cbs_host_model
    import cbs_pkg::*;
(
    input wire logic i_clock,
    output cbs_serial_t o_serial
);
    logic [7:0] last = 8'h00;
    initial o_serial = '0;
    task put(input logic s, input logic p, input logic v, input logic [7:0] b);
        @(posedge i_clock);
        #1;
        o_serial = '{s, p, v, v ? b : ~last};
        if (v)
            last = b;
    endtask
    task frame(input logic [7:0] sa, input logic [31:0] w[$], input int nb);
        put(1'b1, 1'b0, 1'b0, 8'h00);
        put(1'b0, 1'b0, 1'b1, sa);
        foreach (w[i])
            for (int k = nb - 1; k >= 0; k--)
                put(1'b0, 1'b0, 1'b1, w[i][8*k +: 8]);
        put(1'b0, 1'b1, 1'b0, 8'h00);
        put(1'b0, 1'b0, 1'b0, 8'h00);
    endtask
endmodule

// *** testbench/tb_cbs_bank_switch.sv ***
`timescale 1ns/100ps
module tb_cbs_bank_switch;
    import cbs_pkg::*;
    localparam int SLOTS = 31;
    localparam int WORDS = 5;
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic i_enable = 1'b1;
    logic [1:0] i_rate_group = 2'h0;
    logic i_rate_change = 1'b0;
    cbs_serial_t i_serial;
    cbs_coef_t o_coef;
    cbs_coef_t last_coef;
    logic [2:0] o_bank_field;
    logic [1:0] o_active_bank;
    logic o_shutdown;
    logic [7:0] o_volume;
    logic o_volume_unity;
    logic [7:0] o_trim;
    logic [31:0] w;
    logic [31:0] bank_w [3];
    logic [31:0] hit_coef = 32'h0;
    int error_cnt = 0;
    int n_compared = 0;
    int seed = 23306;
    int cycles = 0;
    int n_coef = 0;
    always #12.5 i_clock = ~i_clock;
    cbs_bank_switch i_cbs_bank_switch (.i_clock(i_clock), .i_reset(i_reset), .i_enable(i_enable),
        .i_serial(i_serial), .i_rate_group(i_rate_group), .i_rate_change(i_rate_change),
        .o_coef(o_coef), .o_bank_field(o_bank_field), .o_active_bank(o_active_bank),
        .o_shutdown(o_shutdown), .o_volume(o_volume), .o_volume_unity(o_volume_unity),
        .o_trim(o_trim));
    cbs_host_model i_cbs_host_model (.i_clock(i_clock), .o_serial(i_serial));
    function automatic logic [31:0] sext(input logic [31:0] v);
        return {{6{v[25]}}, v[25:0]};
    endfunction
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wrap_up;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task wr(input logic [7:0] sa, input logic [31:0] q[$], input int nb);
        i_cbs_host_model.frame(sa, q, nb);
        repeat (4) @(posedge i_clock);
        #1;
    endtask
    always @(posedge i_clock)
    begin
        cycles <= cycles + 1;
        if (o_coef.valid === 1'b1)
        begin
            n_coef <= n_coef + 1;
            last_coef <= o_coef;
            if (o_coef.slot == 8'h17 && o_coef.word == 3'h0)
                hit_coef <= o_coef.data;
        end
        if (cycles == 3000)
        begin
            error_cnt++;
            wrap_up;
        end
    end
    initial
    begin
        repeat (12) @(posedge i_clock);
        #1;
        i_reset = 1'b0;
        @(posedge i_clock);
        #1;
        chk("shutdown", 32'h1, 32'(o_shutdown));
        chk("volume", 32'(VOLUME_RESET), 32'(o_volume));
        chk("bank field", 32'h0, 32'(o_bank_field));
        wr(ADDR_TRIM, '{32'h0}, 1);
        chk("trim", 32'h0, 32'(o_trim));
        wr(ADDR_VOLUME, '{32'(VOLUME_UNITY)}, 1);
        chk("unity", 32'h1, 32'(o_volume_unity));
        wr(ADDR_SHUTDOWN, '{32'h0}, 1);
        chk("shutdown", 32'h0, 32'(o_shutdown));
        i_enable = 1'b0;
        wr(ADDR_VOLUME, '{32'h12}, 1);
        chk("frozen volume", 32'(VOLUME_UNITY), 32'(o_volume));
        i_enable = 1'b1;
        $display("test narrow done");
        for (int i = 0; i < 3; i++)
        begin
            w = (i == 0) ? 32'($random(seed)) : (i == 1 ? GAIN_UNITY_323 : GAIN_UNITY_917);
            n_coef = 0;
            wr(COEF_HI_FIRST + 8'(i), '{w}, 4);
            chk("coef count", 32'h1, 32'(n_coef));
            chk("coef slot", 32'(23 + i), 32'(last_coef.slot));
            chk("coef data", sext(w), last_coef.data);
        end
        $display("test direct done");
        n_coef = 0;
        wr(BIQUAD_FIRST, '{w, w}, 4);
        chk("partial biquad", 32'h0, 32'(n_coef));
        wr(BIQUAD_FIRST, '{w, w, w, w, w}, 4);
        chk("biquad seen", 32'h1, 32'(n_coef));
        chk("biquad slot", 32'h0, 32'(last_coef.slot));
        chk("biquad word", 32'h4, 32'(last_coef.word));
        chk("biquad data", sext(w), last_coef.data);
        $display("test biquad done");
        for (int k = 1; k <= 4; k++)
        begin
            wr(ADDR_BANK_CTRL, '{32'(k)}, 4);
            chk("bank field", 32'(k), 32'(o_bank_field));
            n_coef = 0;
            if (k < 4)
            begin
                bank_w[k - 1] = $random(seed);
                wr(COEF_HI_FIRST, '{bank_w[k - 1]}, 4);
            end
            chk("fill silent", 32'h0, 32'(n_coef));
        end
        for (int r = 0; r < 3; r++)
        begin
            n_coef = 0;
            i_rate_group = 2'(2 - r);
            i_rate_change = 1'b1;
            @(posedge i_clock);
            #1;
            i_rate_change = 1'b0;
            repeat (SLOTS * WORDS + 6) @(posedge i_clock);
            #1;
            chk("swap words", 32'(SLOTS * WORDS), 32'(n_coef));
            chk("active bank", 32'(2 - r), 32'(o_active_bank));
            chk("swap data", sext(bank_w[2 - r]), hit_coef);
        end
        wr(ADDR_BANK_CTRL, '{32'h7}, 4);
        chk("bank off", 32'h0, 32'(o_bank_field));
        n_coef = 0;
        i_rate_change = 1'b1;
        @(posedge i_clock);
        #1;
        i_rate_change = 1'b0;
        repeat (8) @(posedge i_clock);
        #1;
        chk("no swap", 32'h0, 32'(n_coef));
        $display("test auto done");
        wrap_up;
    end
endmodule
bind cbs_bank_switch cbs_bank_switch_checker #(.SLOTS(SLOTS), .WORDS(WORDS)) i_chk (
    .i_clock(i_clock), .i_reset(i_reset), .i_serial(i_serial), .i_rate_change(i_rate_change),
    .o_coef(o_coef), .o_bank_field(o_bank_field), .o_active_bank(o_active_bank),
    .o_shutdown(o_shutdown), .o_volume(o_volume), .o_volume_unity(o_volume_unity),
    .o_trim(o_trim));
